// ==== src/ubdpp_defs.svh ====
`ifndef UBDPP_DEFS_SVH
`define UBDPP_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets on the apb window
`define UBDPP_OFS_CONFIG    12'h000
`define UBDPP_OFS_XSTAT     12'h004
`define UBDPP_OFS_PTRS      12'h008
`define UBDPP_OFS_BDT       12'h100
`define UBDPP_BDT_END       12'h1FC

////////////////////////////////////////////////////////////////////////////////
// usb ram window that buffer addresses are meant to point into
`define UBDPP_USB_RAM_LO    16'h0400
`define UBDPP_USB_RAM_HI    16'h04FF

////////////////////////////////////////////////////////////////////////////////
// descriptor_status bit positions
`define UBDPP_ST_OWN        7
`define UBDPP_ST_DTS        6
`define UBDPP_ST_TCHK       3
`define UBDPP_ST_BUFFER_STALL_ENABLE     2

////////////////////////////////////////////////////////////////////////////////
// usb_config_register fields and reset value
`define UBDPP_CFG_MODE_LSB  0
`define UBDPP_CFG_EN        4
`define UBDPP_CFG_PPCLR     5
`define UBDPP_CFG_RST       32'h00000000

////////////////////////////////////////////////////////////////////////////////
// transfer_status_register fields
`define UBDPP_XST_EP_LSB    3
`define UBDPP_XST_DIR       2
`define UBDPP_XST_PAR       1
`define UBDPP_XST_VALID     0

////////////////////////////////////////////////////////////////////////////////
// buffering modes and token pids
`define UBDPP_MODE_NONE     2'h0
`define UBDPP_MODE_EP0OUT   2'h1
`define UBDPP_MODE_ALL      2'h2
`define UBDPP_PID_OUT       4'h1
`define UBDPP_PID_IN        4'h9
`define UBDPP_PID_SETUP     4'hD

`endif

// ==== src/ubdpp_pkg.sv ====
package ubdpp_pkg;

    typedef enum logic [1:0] {UBDPP_HS_ACK, UBDPP_HS_NAK, UBDPP_HS_STALL} ubdpp_hs_t;

    typedef enum logic {UBDPP_ST_IDLE, UBDPP_ST_EVAL} ubdpp_fsm_t;

    typedef enum logic [2:0] {
        UBDPP_REG_CFG,
        UBDPP_REG_XSTAT,
        UBDPP_REG_PTRS,
        UBDPP_REG_BDT,
        UBDPP_REG_NONE
    } ubdpp_reg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } ubdpp_apb_req_t;

    // transaction report from the serial_interface_engine
    typedef struct packed {
        logic [3:0] ep;
        logic [3:0] pid;
        logic       toggle;
        logic       err;
        logic [9:0] count;
    } ubdpp_xact_t;

    typedef struct packed {
        ubdpp_hs_t   hs;
        logic        updated;
        logic [5:0]  bd_index;
        logic        parity;
        logic [15:0] buf_addr;
        logic [9:0]  bd_count;
    } ubdpp_resp_t;

    typedef struct packed {
        ubdpp_fsm_t  fsm;
        logic [1:0]  mode;
        logic        enable;
        logic        ptr_clr;
        logic [31:0] ptr;
        logic [3:0]  st_ep;
        logic        st_dir;
        logic        st_parity;
        logic        st_valid;
        ubdpp_xact_t xact;
        logic        resp_valid;
        ubdpp_resp_t resp;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ubdpp_state_t;

endpackage : ubdpp_pkg

// ==== src/ubdpp_bd_map.sv ====
`timescale 1ns/10ps
`include "ubdpp_defs.svh"

module ubdpp_bd_map (
    input  wire logic [1:0] mode,
    input  wire logic [3:0] ep,
    input  wire logic       dir_in,
    input  wire logic       parity,
    output logic      [5:0] idx
);

    always_comb begin
        case (mode)
            `UBDPP_MODE_EP0OUT: begin
                if (ep == 4'h0 && !dir_in) begin
                    idx = {5'h00, parity};
                end else if (ep == 4'h0) begin
                    idx = 6'h02;
                end else begin
                    idx = {1'b0, ep, 1'b0} + (dir_in ? 6'h02 : 6'h01);
                end
            end
            `UBDPP_MODE_ALL: begin
                idx = {ep, dir_in, parity};
            end
            // the reserved code falls back to no ping-pong
            default: begin
                idx = {1'b0, ep, dir_in};
            end
        endcase
    end

endmodule : ubdpp_bd_map

// ==== src/ubdpp_engine.sv ====
`timescale 1ns/10ps
`include "ubdpp_defs.svh"
// Contract
// - buffer addresses are never checked; used exactly as firmware wrote them
// - status bit 7 set means the engine owns descriptor and buffer
// - engine write-back leaves status bit 6 as it was
// - completed transaction stores token pid in status bits 5 to 2
// - status bits 1 and 0 get top bits of actual byte count
// - ping-pong endpoints have even and odd descriptors per direction
// - two-bit mode picks none, endpoint 0 out only, or all endpoints
// - every even/odd pointer returns to even when module is enabled
// - pointer flips each time a transaction completes and ownership is released
// - last_parity_indicator records which descriptor parity the last completed transaction used
// - pingpong_pointer_clear forces all pointers back to even
// - mode 0 maps endpoint n to 2n out and 2n+1 in
// - mode 1 maps ep0 out to 0/1, ep0 in 2, else 2n+1/2n+2
// - mode 2 maps endpoint n to 4n..4n+3, even then odd
// - descriptor table holds 64 four-byte entries, indexes 0 to 63
// - descriptor entries have no reset value
// - after engine ownership the old toggle-check and stall bits are void
// - expected toggle value ignored unless toggle check is enabled
// - byte count is ten bits, low byte in count, top two in status
// - ownership cleared on completion; an active stall keeps it unless the token is setup
module ubdpp_engine
    import ubdpp_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           nrst,
    input  wire ubdpp_apb_req_t apb_req,
    output logic         [31:0] prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           xact_valid,
    input  wire ubdpp_xact_t    xact,
    output logic                xact_ready,
    output logic                resp_valid,
    output ubdpp_resp_t         resp
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    ubdpp_state_t s_reg;
    ubdpp_state_t s_next;
    logic  [31:0] bdt_mem [0:63];
    logic         x_dir_in;
    logic         x_is_setup;
    logic         x_ptr;
    logic  [5:0]  map_idx;
    logic  [31:0] bd_word;
    logic  [9:0]  bd_cap;
    logic         bd_we;
    logic         apb_we;
    logic  [31:0] wb_word;
    logic  [31:0] rdata;
    ubdpp_reg_t   region;

    function automatic ubdpp_reg_t decode_reg(input logic [11:0] addr);
        ubdpp_reg_t r;
        r = UBDPP_REG_NONE;
        if (addr[1:0] != 2'h0) begin
            r = UBDPP_REG_NONE;
        end else if (addr == `UBDPP_OFS_CONFIG) begin
            r = UBDPP_REG_CFG;
        end else if (addr == `UBDPP_OFS_XSTAT) begin
            r = UBDPP_REG_XSTAT;
        end else if (addr == `UBDPP_OFS_PTRS) begin
            r = UBDPP_REG_PTRS;
        end else if (addr >= `UBDPP_OFS_BDT && addr <= `UBDPP_BDT_END) begin
            r = UBDPP_REG_BDT;
        end
        return r;
    endfunction : decode_reg

    ////////////////////////////////////////////////////////////////////////////
    // descriptor selection

    assign x_dir_in   = (s_reg.xact.pid == `UBDPP_PID_IN);
    assign x_is_setup = (s_reg.xact.pid == `UBDPP_PID_SETUP);
    // pointers sit one per endpoint and direction, bit {ep, dir_in}
    // even or odd select
    assign x_ptr      = s_reg.ptr[{s_reg.xact.ep, x_dir_in}];

    // per-mode tables live in the map
    ubdpp_bd_map u_map (
        .mode   (s_reg.mode),
        .ep     (s_reg.xact.ep),
        .dir_in (x_dir_in),
        .parity (x_ptr),
        .idx    (map_idx)
    );

    assign bd_word = bdt_mem[map_idx];
    assign bd_cap  = {bd_word[1:0], bd_word[15:8]};
    assign region  = decode_reg(apb_req.paddr);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_next            = s_reg;
        s_next.resp_valid = 1'b0;
        bd_we             = 1'b0;
        apb_we            = 1'b0;
        wb_word           = bd_word;
        rdata             = 32'h00000000;

        case (s_reg.fsm)
            UBDPP_ST_IDLE: begin
                if (xact_valid && s_reg.enable) begin
                    s_next.xact = xact;
                    s_next.fsm  = UBDPP_ST_EVAL;
                end
            end
            UBDPP_ST_EVAL: begin
                s_next.fsm           = UBDPP_ST_IDLE;
                s_next.resp_valid    = 1'b1;
                s_next.resp.bd_index = map_idx;
                s_next.resp.parity   = x_ptr;
                s_next.resp.buf_addr = bd_word[31:16];
                s_next.resp.bd_count = bd_cap;
                s_next.resp.updated  = 1'b0;
                s_next.resp.hs       = UBDPP_HS_NAK;
                if (!bd_word[`UBDPP_ST_OWN]) begin
                    s_next.resp.hs = UBDPP_HS_NAK;
                // stall keeps ownership unless setup arrives
                end else if (bd_word[`UBDPP_ST_BUFFER_STALL_ENABLE] && !x_is_setup) begin
                    s_next.resp.hs = UBDPP_HS_STALL;
                end else if (s_reg.xact.err) begin
                    s_next.resp.hs = UBDPP_HS_NAK;
                // oversize receive is refused and the count left alone
                end else if (!x_dir_in && s_reg.xact.count > bd_cap) begin
                    s_next.resp.hs = UBDPP_HS_NAK;
                // toggle compared only with check enabled
                end else if (!x_dir_in && bd_word[`UBDPP_ST_TCHK] &&
                             (s_reg.xact.toggle != bd_word[`UBDPP_ST_DTS])) begin
                    s_next.resp.hs = UBDPP_HS_ACK;
                end else begin
                    s_next.resp.hs      = UBDPP_HS_ACK;
                    s_next.resp.updated = 1'b1;
                    bd_we               = 1'b1;
                    wb_word = {bd_word[31:16], s_reg.xact.count[7:0], 1'b0, bd_word[`UBDPP_ST_DTS],
                               s_reg.xact.pid, s_reg.xact.count[9:8]};
                    s_next.ptr[{s_reg.xact.ep, x_dir_in}] = ~x_ptr;
                    s_next.st_ep     = s_reg.xact.ep;
                    s_next.st_dir    = x_dir_in;
                    s_next.st_parity = x_ptr;
                    s_next.st_valid  = 1'b1;
                end
            end
        endcase

        // apb: pready is held back while a descriptor write-back is pending, so the two never collide
        if (s_reg.pready) begin
            s_next.pready  = 1'b0;
            s_next.pslverr = 1'b0;
            if (apb_req.pwrite && !s_reg.pslverr) begin
                if (region == UBDPP_REG_CFG && apb_req.pstrb[0]) begin
                    s_next.mode    = apb_req.pwdata[`UBDPP_CFG_MODE_LSB +: 2];
                    s_next.enable  = apb_req.pwdata[`UBDPP_CFG_EN];
                    s_next.ptr_clr = apb_req.pwdata[`UBDPP_CFG_PPCLR];
                    if (apb_req.pwdata[`UBDPP_CFG_EN] && !s_reg.enable) begin
                        s_next.ptr = 32'h00000000;
                    end
                end else if (region == UBDPP_REG_BDT) begin
                    apb_we = 1'b1;
                end
            end
        end else if (apb_req.psel && apb_req.penable && s_next.fsm != UBDPP_ST_EVAL) begin
            if (region == UBDPP_REG_CFG) begin
                rdata[`UBDPP_CFG_MODE_LSB +: 2] = s_reg.mode;
                rdata[`UBDPP_CFG_EN]            = s_reg.enable;
                rdata[`UBDPP_CFG_PPCLR]         = s_reg.ptr_clr;
            end else if (region == UBDPP_REG_XSTAT) begin
                rdata[`UBDPP_XST_EP_LSB +: 4] = s_reg.st_ep;
                rdata[`UBDPP_XST_DIR]         = s_reg.st_dir;
                rdata[`UBDPP_XST_PAR]         = s_reg.st_parity;
                rdata[`UBDPP_XST_VALID]       = s_reg.st_valid;
            end else if (region == UBDPP_REG_PTRS) begin
                rdata = s_reg.ptr;
            end else if (region == UBDPP_REG_BDT) begin
                rdata = bdt_mem[apb_req.paddr[7:2]];
            end
            s_next.pready  = 1'b1;
            s_next.pslverr = (region == UBDPP_REG_NONE);
            s_next.prdata  = rdata;
        end

        // clear holds all pointers even, winning over a flip
        if (s_reg.ptr_clr) begin
            s_next.ptr = 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_reg <= ubdpp_state_t'(0);
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // descriptor table

    always_ff @(posedge clk_sys) begin
        if (bd_we) begin
            bdt_mem[map_idx] <= wb_word;
        end else if (apb_we) begin
            for (int b = 0; b < 4; b++) begin
                if (apb_req.pstrb[b]) begin
                    bdt_mem[apb_req.paddr[7:2]][8*b +: 8] <= apb_req.pwdata[8*b +: 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata     = s_reg.prdata;
    assign pready     = s_reg.pready;
    assign pslverr    = s_reg.pslverr;
    assign xact_ready = (s_reg.fsm == UBDPP_ST_IDLE) && s_reg.enable;
    assign resp_valid = s_reg.resp_valid;
    assign resp       = s_reg.resp;

endmodule : ubdpp_engine

// ==== sim/ubdpp_engine_sva.sv ====
`timescale 1ns/10ps
module ubdpp_engine_sva
    import ubdpp_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           nrst,
    input  wire ubdpp_apb_req_t apb_req,
    input  wire logic           pready,
    input  wire logic           pslverr,
    input  wire logic           xact_valid,
    input  wire ubdpp_xact_t    xact,
    input  wire logic           xact_ready,
    input  wire logic           resp_valid,
    input  wire ubdpp_resp_t    resp
);
    logic taken;
    logic taken_err;
    assign taken     = xact_valid && xact_ready;
    assign taken_err = taken && xact.err;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    chk_pready_cause: assert property (pready |-> apb_req.psel && apb_req.penable)
        else $error("pready outside an access");
    chk_pready_wait: assert property (apb_req.psel && apb_req.penable && !pready |-> ##[1:2] pready)
        else $error("pready too late");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unaligned_err: assert property (pready && apb_req.paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    chk_resp_delay: assert property (taken |-> ##2 resp_valid)
        else $error("response not two cycles after report");
    chk_resp_cause: assert property (resp_valid |-> $past(taken, 2))
        else $error("response without report");
    chk_busy_eval: assert property (taken |=> !xact_ready)
        else $error("report taken during evaluation");
    chk_stall_keep: assert property (resp_valid && resp.hs == UBDPP_HS_STALL |-> !resp.updated)
        else $error("stall rewrote descriptor");
    chk_nak_keep: assert property (resp_valid && resp.hs == UBDPP_HS_NAK |-> !resp.updated)
        else $error("nak rewrote descriptor");
    chk_err_nak: assert property (resp_valid && $past(taken_err, 2) |-> resp.hs != UBDPP_HS_ACK)
        else $error("errored packet acknowledged");
endmodule : ubdpp_engine_sva

bind ubdpp_engine ubdpp_engine_sva ubdpp_engine_sva_inst (.clk_sys(clk_sys), .nrst(nrst), .apb_req(apb_req),
    .pready(pready), .pslverr(pslverr), .xact_valid(xact_valid), .xact(xact), .xact_ready(xact_ready),
    .resp_valid(resp_valid), .resp(resp));

// ==== sim/ubdpp_sie_model.sv ====
`timescale 1ns/10ps
module ubdpp_sie_model
    import ubdpp_pkg::*;
(
    input  wire logic  clk_sys,
    input  wire logic  xact_ready,
    output logic       xact_valid,
    output ubdpp_xact_t xact
);
    initial begin
        xact_valid = 1'b0;
        xact       = '0;
    end
    // gap lets the far side offer promptly or after a pause
    task automatic send(input ubdpp_xact_t x, input int gap);
        repeat (gap) @(posedge clk_sys);
        xact_valid <= 1'b1;
        xact       <= x;
        do @(posedge clk_sys); while (xact_ready !== 1'b1);
        xact_valid <= 1'b0;
        // released lines flip so a stale report cannot pass for a live one
        xact       <= ~x;
        @(posedge clk_sys);
    endtask : send
endmodule : ubdpp_sie_model

// ==== sim/ubdpp_engine_tb_top.sv ====
`timescale 1ns/10ps
`include "ubdpp_defs.svh"
module ubdpp_engine_tb_top
    import ubdpp_pkg::*;
;
    localparam logic [11:0] CFG = `UBDPP_OFS_CONFIG;
    localparam logic [11:0] XST = `UBDPP_OFS_XSTAT;
    localparam logic [11:0] PTR = `UBDPP_OFS_PTRS;
    localparam logic [3:0]  PO  = `UBDPP_PID_OUT;
    localparam logic [3:0]  PI  = `UBDPP_PID_IN;
    localparam logic [3:0]  PS  = `UBDPP_PID_SETUP;
    logic           clk_sys;
    logic           nrst;
    ubdpp_apb_req_t ap;
    logic    [31:0] prdata;
    logic           pready;
    logic           pslverr;
    logic           xact_valid;
    ubdpp_xact_t    xact;
    logic           xact_ready;
    logic           resp_valid;
    ubdpp_resp_t    resp;
    logic    [31:0] ptr_m;
    logic     [1:0] mode_m;
    logic     [3:0] ep_r;
    logic    [31:0] seed_v;
    logic    [33:0] aq[$];
    ubdpp_resp_t    rq[$];
    logic     [3:0] pids[3] = '{PO, PI, PS};
    int             error_cnt = 0;
    int             check_count = 0;

    ubdpp_engine ubdpp_engine_inst (.clk_sys(clk_sys), .nrst(nrst), .apb_req(ap), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xact_valid(xact_valid), .xact(xact), .xact_ready(xact_ready),
        .resp_valid(resp_valid), .resp(resp));
    ubdpp_sie_model sie_inst (.clk_sys(clk_sys), .xact_ready(xact_ready), .xact_valid(xact_valid), .xact(xact));

    always #50 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [63:0] s, input logic [63:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            check("pslverr", 64'(pslverr), 64'(aq[0][32]));
            if (!aq[0][33]) check("prdata", 64'(prdata), 64'(aq[0][31:0]));
            void'(aq.pop_front());
        end
        if (resp_valid === 1'b1) check("resp", 64'(resp), 64'(rq.pop_front()));
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e,
                       input logic [31:0] x);
        aq.push_back({w, e, x});
        ap <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hF};
        @(posedge clk_sys);
        ap.penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        ap.psel    <= 1'b0;
        ap.penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic run(input logic [3:0] ep, input logic [3:0] pid, input logic [7:0] st, input logic [7:0] cn,
                       input logic tg, input logic er, input logic [9:0] n);
        logic        d;
        logic        p;
        logic        upd;
        logic [5:0]  ix;
        logic [15:0] a;
        logic [11:0] ad;
        ubdpp_hs_t   hs;
        d   = (pid == PI);
        p   = ptr_m[{ep, d}];
        ix  = mode_m == 2'h2 ? {ep, d, p} : mode_m == 2'h1 ?
              (ep == 4'h0 ? (d ? 6'h02 : {5'h00, p}) : {1'b0, ep, 1'b0} + 6'h01 + 6'(d)) : {1'b0, ep, d};
        a   = 16'($urandom);
        // about half the buffers sit in usb ram, the rest exercise
        if (a[15]) a = `UBDPP_USB_RAM_LO | {8'h00, a[7:0]};
        // only the mapped slot of the endpoint is written
        ad  = 12'h100 + {4'h0, ix, 2'b00};
        upd = 1'b0;
        hs  = UBDPP_HS_ACK;
        // address kept as written, even outside usb ram
        // check and stall bits armed in the same word as ownership
        apb(1'b1, ad, {a, cn, st}, 1'b0, 32'h0);
        if (!st[7]) hs = UBDPP_HS_NAK;
        else if (st[2] && pid != PS) hs = UBDPP_HS_STALL;
        else if (er || (!d && n > {st[1:0], cn})) hs = UBDPP_HS_NAK;
        else upd = !(!d && st[3] && tg != st[6]);
        rq.push_back({hs, upd, ix, p, a, st[1:0], cn});
        sie_inst.send({ep, pid, tg, er, n}, $urandom % 3);
        while (rq.size() != 0) @(posedge clk_sys);
        if (upd) begin
            ptr_m[{ep, d}] = !p;
            apb(1'b0, XST, 32'h0, 1'b0, {25'h0, ep, d, p, 1'b1});
            // old check and stall bits are void
            st = {1'b0, st[6], pid, n[9:8]};
            cn = n[7:0];
        end
        apb(1'b0, ad, 32'h0, 1'b0, {a, cn, st});
    endtask : run
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        nrst    = 1'b0;
        ap      = '0;
        ptr_m   = '0;
        mode_m  = 2'h0;
        seed_v  = $urandom(32'h1BD6);
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        check("idle_ready", 64'(xact_ready), 64'h0);
        apb(1'b0, CFG, 32'h0, 1'b0, `UBDPP_CFG_RST);
        apb(1'b1, PTR, 32'hFFFFFFFF, 1'b0, 32'h0);
        apb(1'b0, PTR, 32'h0, 1'b0, 32'h0);
        apb(1'b0, 12'h020, 32'h0, 1'b1, 32'h0);
        apb(1'b1, 12'h102, 32'h0, 1'b1, 32'h0);
        // mode 3 is reserved and must map as mode 0
        for (int m = 0; m < 4; m++) begin
            mode_m = 2'(m);
            apb(1'b1, CFG, 32'h0, 1'b0, 32'h0);
            // mode select, pointers even on enable
            apb(1'b1, CFG, 32'h10 | 32'(m), 1'b0, 32'h0);
            apb(1'b0, CFG, 32'h0, 1'b0, 32'h10 | 32'(m));
            ptr_m = '0;
            ep_r  = 4'($urandom);
            for (int k = 0; k < 6; k++) run(k < 3 ? 4'h0 : ep_r, pids[k % 3], 8'h83, 8'hFF, 1'($urandom),
                                             1'b0, 10'($urandom));
            apb(1'b0, PTR, 32'h0, 1'b0, ptr_m);
        end
        run(4'h5, PO, 8'h03, 8'h10, 1'b0, 1'b0, 10'h004);
        run(4'h5, PO, 8'h87, 8'h10, 1'b0, 1'b0, 10'h004);
        run(4'h5, PS, 8'h87, 8'h10, 1'b0, 1'b0, 10'h008);
        run(4'h5, PO, 8'h88, 8'h10, 1'b1, 1'b0, 10'h004);
        run(4'h5, PO, 8'hC8, 8'h10, 1'b1, 1'b0, 10'h004);
        run(4'h5, PO, 8'hC0, 8'h10, 1'b0, 1'b0, 10'h004);
        run(4'h5, PO, 8'h80, 8'h10, 1'b0, 1'b0, 10'h011);
        run(4'h5, PO, 8'h80, 8'h10, 1'b0, 1'b0, 10'h010);
        run(4'h5, PI, 8'h80, 8'h00, 1'b0, 1'b0, 10'h3FF);
        run(4'h5, PO, 8'h80, 8'hFF, 1'b0, 1'b1, 10'h004);
        apb(1'b1, CFG, 32'h32, 1'b0, 32'h0);
        apb(1'b1, CFG, 32'h12, 1'b0, 32'h0);
        ptr_m  = '0;
        mode_m = 2'h2;
        apb(1'b0, PTR, 32'h0, 1'b0, 32'h0);
        run(4'h5, PI, 8'h80, 8'h20, 1'b0, 1'b0, 10'h020);
        final_report();
    end
endmodule : ubdpp_engine_tb_top
